// [rtl/adc_seq_consts.svh]
// Offsets, field positions, reset values and phase lengths of the sequencer.
// Assumes one clock (the converter master clock) for all logic.
//
// Behaviour
// - chopped cycle opens with 43/44-cycle settle
// - sample length from channel filter word
// - chopped: settle 42, resample reversed polarity
// - 163-cycle scale phase averages, calibrates, stores
// - unchopped: settle, one sample, scale
// - ready pin high during every scale phase
// - cycle end sets ready bits, ready pin low
// - continuous mode moves to next enabled channel
// - conversion time and chopping held per channel
// - modulator runs at half master clock
// - low reference during conversion sets missing flag
// - sync enabled and gate low blocks conversion
// - gated request starts on gate rising edge
// - pin zero GPIO, pin one GPIO or gate
// - unipolar two-stage offset and gain scaling
// - bipolar divides by 400000h, adds 800000h
// - raw result unsigned, zero to FFFFFFh
// - channel offset is sign plus 22-bit magnitude
// - calibration end: registers, ready bits, gate low, idle
// - calibration lasts unchopped channel conversion time; only ADC zero-scale shorts inputs
// - data read at completion discards new result
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

// ****************************************
// Phase lengths, master clock cycles
// ****************************************
`define SETTLE_FIRST  18'h0_002C
`define SETTLE_NEXT   18'h0_002B
`define SETTLE_CHOP   18'h0_002A
`define SCALE_CYC     18'h0_00A3

// ****************************************
// Register offsets and fields
// ****************************************
`define OFF_MODE      8'h00
`define OFF_STATUS    8'h04
`define OFF_IOPORT    8'h08
`define OFF_ADC_ZS    8'h0C
`define OFF_ADC_FS    8'h10
`define FLD_CH_STAT   3'h0
`define FLD_CH_DATA   3'h1
`define FLD_CH_ZS     3'h2
`define FLD_CH_FS     3'h3
`define FLD_CH_SETUP  3'h4
`define SETUP_CHOP    16
`define SETUP_EN      17
`define SETUP_BIP     18
`define IO_SYNC_EN    4
`define RST_FW        16'h0010
`define RST_GAIN      24'h20_0000
`define BIP_OFFSET    64'sh0000_0000_0080_0000
`define CAL_DIVIDEND  {24'hFF_FFFF, 21'h0_0000}

`endif

// [rtl/adc_seq_pkg.sv]
// Types of the conversion sequencer: states, modes, register bus and state record.
// Assumes the constants header sits beside it.
`include "adc_seq_consts.svh"

package adc_seq_pkg;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b000_0001,
    ST_GATE   = 7'b000_0010,
    ST_SETTLE = 7'b000_0100,
    ST_SAMP1  = 7'b000_1000,
    ST_RESETL = 7'b001_0000,
    ST_SAMP2  = 7'b010_0000,
    ST_SCALE  = 7'b100_0000
  } seq_state_t;

  typedef enum logic [2:0] {
    MD_IDLE = 3'h0, MD_SINGLE = 3'h1, MD_CONT = 3'h2,
    MD_ADC_ZS = 3'h3, MD_CH_ZS = 3'h4, MD_CH_FS = 3'h5
  } mode_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drv_t;

  typedef struct packed {
    seq_state_t       state;
    mode_t            mode;
    logic [1:0]       sel;
    logic [1:0]       cur;
    logic [17:0]      cnt;
    logic [23:0]      raw1;
    logic [23:0]      raw2;
    logic [4:0]       io;
    logic             hold_low;
    logic [23:0]      adc_zs;
    logic [23:0]      adc_fs;
    logic [3:0][23:0] ch_data;
    logic [3:0][22:0] ch_zs;
    logic [3:0][23:0] ch_fs;
    logic [3:0][18:0] ch_setup;
    logic [3:0]       rdy;
    logic [3:0]       ch_rdy;
    logic [3:0]       reference_missing_flag;
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic             gate_d;
    logic             ref1;
    logic             ref2;
    logic [24:0]      div_rem;
    logic [44:0]      div_q;
    logic [23:0]      div_d;
    logic [5:0]       div_n;
    logic [31:0]      rdata;
    logic             rdy_n;
    pin_drv_t         io0;
    pin_drv_t         io1;
  } seq_regs_t;

endpackage

// [rtl/adc_conversion_sequencer_cal.sv]
// Conversion sequencer with calibration arithmetic for a multiplexed sigma-delta converter.
// Assumes the filter result is valid on the last cycle of each sample phase,
// and that the register port runs on the same master clock.
`timescale 1ns/100ps
`include "adc_seq_consts.svh"

module adc_conversion_sequencer_cal
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire reg_req_t    req,
  output logic [31:0]      rdata,
  // Converter front end
  input  wire logic [23:0] filt_result,
  input  wire logic        ref_low,
  output logic [1:0]       mux_ch,
  output logic             chop_rev,
  output logic             mod_run,
  output logic             mod_clk_en,
  output logic             inputs_shorted,
  output logic             busy,
  // Ready pin, active low
  output logic             rdy_n,
  // Port pins
  input  wire logic        general_io_zero_in,
  output pin_drv_t         general_io_zero_drv,
  input  wire logic        general_io_one_in,
  output pin_drv_t         general_io_one_drv
);

  // ****************************************
  // State record
  // ****************************************
  seq_regs_t s;
  seq_regs_t n;

  // ****************************************
  // Scaling arithmetic
  // ****************************************
  logic               is_cal;
  logic               chop_on;
  logic               bip_on;
  logic [24:0]        raw_sum;
  logic [23:0]        raw_avg;
  logic signed [63:0] m_diff;
  logic signed [63:0] m_prod;
  logic signed [63:0] m_a;
  logic signed [63:0] zs_val;
  logic signed [63:0] m_b;
  logic signed [63:0] m_c;
  logic [23:0]        scaled;
  logic [22:0]        zs_code;
  logic [23:0]        fs_code;

  // Picks the next enabled channel after the current one, wrapping round
  function automatic logic [1:0] next_ch(input logic [1:0] c, input logic [3:0] en);
    logic [1:0] r;
    logic [1:0] k;
    r = c;
    for (int i = 3; i >= 1; i--) begin
      k = c + 2'(i);
      if (en[k]) begin
        r = k;
      end
    end
    return r;
  endfunction

  // Averaging of chopped pair, then converter and channel stages
  always_comb begin
    is_cal  = (s.mode == MD_ADC_ZS) || (s.mode == MD_CH_ZS) || (s.mode == MD_CH_FS);
    chop_on = s.ch_setup[s.cur][`SETUP_CHOP] && !is_cal;
    bip_on  = s.ch_setup[s.cur][`SETUP_BIP];
    raw_sum = {1'b0, s.raw1} + {1'b0, s.raw2};
    raw_avg = chop_on ? raw_sum[24:1] : s.raw1;
    // Raw result taken as unsigned 24-bit
    m_diff  = $signed({40'h0, raw_avg}) - $signed({40'h0, s.adc_zs});
    m_prod  = m_diff * $signed({40'h0, s.adc_fs});
    if (bip_on) begin
      m_a = (m_prod >>> 22) + `BIP_OFFSET;
    end else begin
      m_a = m_prod >>> 21;
    end
    // Sign bit over 22-bit magnitude
    zs_val = s.ch_zs[s.cur][22] ? -$signed({42'h0, s.ch_zs[s.cur][21:0]})
                                : $signed({42'h0, s.ch_zs[s.cur][21:0]});
    m_b = m_a - zs_val;
    m_c = (m_b * $signed({40'h0, s.ch_fs[s.cur]})) >>> 21;
    if (m_c < 0) begin
      scaled = 24'h00_0000;
    end else if (m_c > 64'sh0000_0000_00FF_FFFF) begin
      scaled = 24'hFF_FFFF;
    end else begin
      scaled = m_c[23:0];
    end
    // Offset code saturates at the 22-bit magnitude
    if (m_a < 0) begin
      zs_code = {1'b1, (-m_a > 64'sh0000_0000_003F_FFFF) ? 22'h3F_FFFF : 22'((-m_a))};
    end else begin
      zs_code = {1'b0, (m_a > 64'sh0000_0000_003F_FFFF) ? 22'h3F_FFFF : m_a[21:0]};
    end
    fs_code = (|s.div_q[44:24]) ? 24'hFF_FFFF : s.div_q[23:0];
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  logic       gate_rise;
  logic       gated;
  logic       running;
  logic [3:0] rdy_set;
  logic [3:0] ch_rdy_set;
  logic [3:0] rdy_clr;
  logic [3:0] reference_missing_flag_clr;
  logic [1:0] a_ch;
  logic [2:0] a_fld;
  logic [24:0] rem_t;
  logic [17:0] samp_len;
  logic        data_busy;

  always_comb begin
    n          = s;
    rdy_set    = 4'h0;
    ch_rdy_set = 4'h0;
    rdy_clr    = 4'h0;
    reference_missing_flag_clr  = 4'h0;
    a_ch       = req.addr[6:5];
    a_fld      = req.addr[4:2];
    rem_t      = 25'h000_0000;
    samp_len   = 18'h0_0000;
    n.rdata    = 32'h0000_0000;

    // Two-stage synchronisers; only the second stage is read
    n.sync1  = {general_io_one_in, general_io_zero_in};
    n.sync2  = s.sync1;
    n.gate_d = s.sync2[1];
    n.ref1   = ref_low;
    n.ref2   = s.ref1;
    gate_rise = s.sync2[1] && !s.gate_d;
    gated     = s.io[`IO_SYNC_EN] && !s.sync2[1];
    running   = (s.state != ST_IDLE) && (s.state != ST_GATE);
    samp_len  = (s.ch_setup[s.cur][15:0] == 16'h0000) ? 18'h0_0002
              : {1'b0, s.ch_setup[s.cur][15:0], 1'b0};
    // A data read of the channel being stored blocks the store
    data_busy = req.rd && req.addr[7] && (a_ch == s.cur) && (a_fld == `FLD_CH_DATA);

    // Missing reference during a conversion
    if (running && !is_cal && s.ref2) begin
      n.reference_missing_flag[s.cur] = 1'b1;
    end

    // Sequencer
    unique case (s.state)
      ST_IDLE: begin
        n.cnt = 18'h0_0000;
      end
      ST_GATE: begin
        // Waits for the gate edge; a cleared enable releases it too
        if (gate_rise || !s.io[`IO_SYNC_EN]) begin
          n.state = ST_SETTLE;
          n.cnt   = `SETTLE_FIRST;
        end
      end
      ST_SETTLE: begin
        n.cnt = s.cnt - 18'h0_0001;
        if (s.cnt == 18'h0_0001) begin
          n.state = ST_SAMP1;
          n.cnt   = samp_len;
        end
      end
      ST_SAMP1: begin
        n.cnt = s.cnt - 18'h0_0001;
        if (s.cnt == 18'h0_0001) begin
          n.raw1 = filt_result;
          if (chop_on) begin
            n.state = ST_RESETL;
            n.cnt   = `SETTLE_CHOP;
          end else begin
            n.state = ST_SCALE;
            n.cnt   = `SCALE_CYC;
          end
        end
      end
      ST_RESETL: begin
        n.cnt = s.cnt - 18'h0_0001;
        if (s.cnt == 18'h0_0001) begin
          n.state = ST_SAMP2;
          n.cnt   = samp_len;
        end
      end
      ST_SAMP2: begin
        n.cnt = s.cnt - 18'h0_0001;
        if (s.cnt == 18'h0_0001) begin
          n.raw2  = filt_result;
          n.state = ST_SCALE;
          n.cnt   = `SCALE_CYC;
        end
      end
      ST_SCALE: begin
        n.cnt = s.cnt - 18'h0_0001;
        // Gain division runs inside the scale phase, 45 steps
        if (s.cnt == `SCALE_CYC) begin
          n.div_d   = (m_b <= 0) ? 24'h00_0000
                    : (m_b > 64'sh0000_0000_00FF_FFFF) ? 24'hFF_FFFF : m_b[23:0];
          n.div_q   = `CAL_DIVIDEND;
          n.div_rem = 25'h000_0000;
          n.div_n   = 6'd45;
        end else if (s.div_n != 6'd0) begin
          rem_t   = {s.div_rem[23:0], s.div_q[44]};
          n.div_n = s.div_n - 6'd1;
          if (rem_t >= {1'b0, s.div_d}) begin
            n.div_rem = rem_t - {1'b0, s.div_d};
            n.div_q   = {s.div_q[43:0], 1'b1};
          end else begin
            n.div_rem = rem_t;
            n.div_q   = {s.div_q[43:0], 1'b0};
          end
        end
        if (s.cnt == 18'h0_0001) begin
          if (is_cal) begin
            // Calibration done: registers, all ready bits, gate pulled low
            unique case (s.mode)
              MD_ADC_ZS: n.adc_zs = raw_avg;
              MD_CH_ZS:  n.ch_zs[s.cur] = zs_code;
              MD_CH_FS: begin
                if (s.div_d != 24'h00_0000) begin
                  n.ch_fs[s.cur] = fs_code;
                end
              end
              default: n.adc_zs = s.adc_zs;
            endcase
            rdy_set    = 4'hF;
            n.hold_low = 1'b1;
            n.mode     = MD_IDLE;
            n.state    = ST_IDLE;
          end else begin
            if (!data_busy) begin
              n.ch_data[s.cur]  = scaled;
              rdy_set[s.cur]    = 1'b1;
              ch_rdy_set[s.cur] = 1'b1;
              n.rdy_n           = 1'b0;
            end
            // Otherwise the new result is dropped
            if (s.mode == MD_CONT) begin
              n.cur   = next_ch(s.cur, {s.ch_setup[3][`SETUP_EN], s.ch_setup[2][`SETUP_EN],
                                        s.ch_setup[1][`SETUP_EN], s.ch_setup[0][`SETUP_EN]});
              n.state = ST_SETTLE;
              n.cnt   = `SETTLE_NEXT;
            end else begin
              n.mode  = MD_IDLE;
              n.state = ST_IDLE;
            end
          end
        end
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase

    // Ready pin forced high while scaling
    if (n.state == ST_SCALE) begin
      n.rdy_n = 1'b1;
    end

    // A low gate suspends the cycle; it restarts from settling on the edge
    if (running && gated) begin
      n.state = ST_GATE;
    end

    // Register reads, data in the following cycle
    if (req.rd) begin
      if (req.addr[7]) begin
        unique case (a_fld)
          `FLD_CH_STAT: begin
            n.rdata        = {26'h000_0000, a_ch, 2'b00, s.reference_missing_flag[a_ch], s.ch_rdy[a_ch]};
            reference_missing_flag_clr[a_ch] = 1'b1;
          end
          `FLD_CH_DATA: begin
            n.rdata      = {8'h00, s.ch_data[a_ch]};
            rdy_clr[a_ch] = 1'b1;
          end
          `FLD_CH_ZS:    n.rdata = {9'h000, s.ch_zs[a_ch]};
          `FLD_CH_FS:    n.rdata = {8'h00, s.ch_fs[a_ch]};
          `FLD_CH_SETUP: n.rdata = {13'h0000, s.ch_setup[a_ch]};
          default:       n.rdata = 32'h0000_0000;
        endcase
      end else begin
        unique case (req.addr)
          `OFF_MODE:   n.rdata = {26'h000_0000, s.sel, 1'b0, s.mode};
          `OFF_STATUS: n.rdata = {16'h0000, 1'b0, s.state, running, 3'h0, s.rdy};
          `OFF_IOPORT: n.rdata = {25'h000_0000, s.sync2, s.io};
          `OFF_ADC_ZS: n.rdata = {8'h00, s.adc_zs};
          `OFF_ADC_FS: n.rdata = {8'h00, s.adc_fs};
          default:     n.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Register writes
    if (req.wr) begin
      if (req.addr[7]) begin
        unique case (a_fld)
          `FLD_CH_ZS:    n.ch_zs[a_ch]    = req.wdata[22:0];
          `FLD_CH_FS:    n.ch_fs[a_ch]    = req.wdata[23:0];
          `FLD_CH_SETUP: n.ch_setup[a_ch] = req.wdata[18:0];
          default:       n.ch_zs[a_ch]    = s.ch_zs[a_ch];
        endcase
      end else begin
        unique case (req.addr)
          `OFF_IOPORT: n.io     = req.wdata[4:0];
          `OFF_ADC_ZS: n.adc_zs = req.wdata[23:0];
          `OFF_ADC_FS: n.adc_fs = req.wdata[23:0];
          `OFF_MODE: begin
            n.sel      = req.wdata[5:4];
            n.cur      = req.wdata[5:4];
            n.hold_low = 1'b0;
            if (req.wdata[2:0] <= 3'h5) begin
              n.mode = mode_t'(req.wdata[2:0]);
            end else begin
              n.mode = MD_IDLE;
            end
            if ((req.wdata[2:0] == 3'h0) || (req.wdata[2:0] > 3'h5)) begin
              n.state = ST_IDLE;
            end else if (gated) begin
              n.state = ST_GATE;
            end else begin
              n.state = ST_SETTLE;
              n.cnt   = `SETTLE_FIRST;
            end
          end
          default: n.io = s.io;
        endcase
      end
    end

    // Set wins over clear
    n.rdy    = (s.rdy & ~rdy_clr) | rdy_set;
    n.ch_rdy = (s.ch_rdy & ~rdy_clr) | ch_rdy_set;
    n.reference_missing_flag  = (n.reference_missing_flag & ~reference_missing_flag_clr) | (s.reference_missing_flag & ~reference_missing_flag_clr & 4'h0) |
               (running && !is_cal && s.ref2 ? (4'h1 << s.cur) : 4'h0);

    // Port pins; pin one becomes an input while used as the gate
    n.io0.out = s.io[0];
    n.io0.oe  = s.io[2];
    n.io1.out = n.hold_low ? 1'b0 : n.io[1];
    n.io1.oe  = n.hold_low || (n.io[3] && !n.io[`IO_SYNC_EN]);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s          <= '0;
      s.state    <= ST_IDLE;
      s.mode     <= MD_IDLE;
      s.adc_fs   <= `RST_GAIN;
      s.ch_fs    <= {4{`RST_GAIN}};
      s.ch_setup <= {4{3'b000, `RST_FW}};
      s.rdy_n    <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Modulator ticks every second master clock while sampling
  assign mod_run             = (s.state == ST_SAMP1) || (s.state == ST_SAMP2);
  assign mod_clk_en          = mod_run && s.cnt[0];
  assign mux_ch              = s.cur;
  assign chop_rev            = (s.state == ST_RESETL) || (s.state == ST_SAMP2);
  assign inputs_shorted      = (s.mode == MD_ADC_ZS);
  assign busy                = (s.state != ST_IDLE);
  assign rdy_n               = s.rdy_n;
  assign rdata               = s.rdata;
  assign general_io_zero_drv = s.io0;
  assign general_io_one_drv  = s.io1;

endmodule

// [test/adc_seq_props.sv]
// Port assertions for the conversion sequencer, bound to its top module.
// Assumes one master clock and an asynchronous active-high reset.
`timescale 1ns/100ps

module adc_seq_props
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Observed ports
  input  wire reg_req_t    req,
  input  wire logic [31:0] rdata,
  input  wire logic        chop_rev,
  input  wire logic        mod_run,
  input  wire logic        mod_clk_en,
  input  wire logic        inputs_shorted,
  input  wire logic        busy,
  input  wire logic        rdy_n,
  input  wire logic        general_io_one_in
);
  // ****************************************
  // Helper state
  // ****************************************
  logic sync_en_r;
  logic cal_r;
  logic mode_wr;

  // Mode writes seen on the bus
  assign mode_wr = req.wr && req.addr == 8'h00;

  // Sync enable and calibration are invisible at the ports, so track the writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_en_r <= 1'b0;
      cal_r     <= 1'b0;
    end else begin
      if (req.wr && req.addr == 8'h08) sync_en_r <= req.wdata[4];
      if (mode_wr) cal_r <= req.wdata[2:0] inside {3'h3, 3'h4, 3'h5};
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Scale phase opens when a sample phase ends outside the reversed half
  sequence scale_start;
    $fell(mod_run) && !chop_rev && busy && !cal_r;
  endsequence

  // Ungated start of any conversion or calibration
  sequence run_start;
    mode_wr && req.wdata[2:0] inside {[3'h1:3'h5]} && !sync_en_r;
  endsequence

  settle_first_a: assert property (run_start |-> ##1 !mod_run[*8] ##36 !mod_run ##1 mod_run)
    else $error("first settle length wrong");
  chop_settle_a: assert property ($fell(mod_run) && chop_rev |-> !mod_run[*8] ##34 !mod_run ##1 (mod_run && chop_rev))
    else $error("chop settle length wrong");
  scale_rdy_a: assert property (scale_start |-> rdy_n[*8])
    else $error("ready pin low in scale phase");
  scale_len_a: assert property (scale_start |-> ##162 rdy_n
    ##1 (!rdy_n || $past(req.rd && req.addr[4:2] == 3'h1)))
    else $error("scale length or ready pin wrong");
  mod_half_a: assert property ($rose(mod_run) |-> !mod_clk_en ##1 mod_clk_en)
    else $error("modulator tick not at half rate");
  rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  gate_block_a: assert property ((sync_en_r && !general_io_one_in)[*4] |-> !mod_run)
    else $error("sampling while gated");
  shorted_cal_a: assert property (mode_wr && req.wdata[2:0] == 3'h3 |=> inputs_shorted && busy)
    else $error("inputs not shorted in self calibration");
endmodule

bind adc_conversion_sequencer_cal adc_seq_props u_props (
  .clk               (clk),
  .rst               (rst),
  .req               (req),
  .rdata             (rdata),
  .chop_rev          (chop_rev),
  .mod_run           (mod_run),
  .mod_clk_en        (mod_clk_en),
  .inputs_shorted    (inputs_shorted),
  .busy              (busy),
  .rdy_n             (rdy_n),
  .general_io_one_in (general_io_one_in)
);

// [test/adc_host_model.sv]
// Host microcontroller model driving the sequencer register port.
// Assumes the device answers a read in the next cycle and never stalls.
`timescale 1ns/100ps

module adc_host_model
  import adc_seq_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register port
  output reg_req_t         req,
  input  wire logic [31:0] rdata
);
  initial req = '0;

  // One-cycle write strobe, released at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
endmodule

// [test/test_adc_conversion_sequencer_cal.sv]
// Self-checking bench for the conversion sequencer.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/100ps

module test_adc_conversion_sequencer_cal
  import adc_seq_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk      = 1'b0;
  logic        rst      = 1'b1;
  logic [23:0] fa       = 24'h12_3456;
  logic [23:0] fb       = 24'h00_0000;
  logic        ref_low  = 1'b0;
  logic        pin0_ext = 1'b0;
  logic        pin1_ext = 1'b1;
  reg_req_t    req;
  logic [31:0] rdata;
  logic [23:0] filt;
  logic [1:0]  mux_ch;
  logic        chop_rev;
  logic        mod_run;
  logic        mod_clk_en;
  logic        inputs_shorted;
  logic        busy;
  logic        rdy_n;
  logic        io0_in;
  logic        io1_in;
  pin_drv_t    io0_drv;
  pin_drv_t    io1_drv;
  int          err_total = 0;
  int          checked   = 0;
  int          n;

  // Reversed half of a chopped cycle sees the second filter value
  assign filt   = chop_rev ? fb : fa;
  // Pin level resolves the driver against the outside world
  assign io0_in = io0_drv.oe ? io0_drv.out : pin0_ext;
  assign io1_in = io1_drv.oe ? io1_drv.out : pin1_ext;

  always #12.5 clk = ~clk;

  adc_conversion_sequencer_cal dut (
    .clk                 (clk),
    .rst                 (rst),
    .req                 (req),
    .rdata               (rdata),
    .filt_result         (filt),
    .ref_low             (ref_low),
    .mux_ch              (mux_ch),
    .chop_rev            (chop_rev),
    .mod_run             (mod_run),
    .mod_clk_en          (mod_clk_en),
    .inputs_shorted      (inputs_shorted),
    .busy                (busy),
    .rdy_n               (rdy_n),
    .general_io_zero_in  (io0_in),
    .general_io_zero_drv (io0_drv),
    .general_io_one_in   (io1_in),
    .general_io_one_drv  (io1_drv)
  );

  adc_host_model host (
    .clk   (clk),
    .req   (req),
    .rdata (rdata)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host.rd(a, v);
    check(v, exp);
  endtask

  // Counts edges from the start until the sequencer is idle again
  task automatic wait_idle(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
    end while (busy !== 1'b0 && cnt < 3000);
    if (busy !== 1'b0) begin
      err_total++;
      end_of_test();
    end
  endtask

  // Ready pin must first rise in the scale phase, then fall at its end
  task automatic wait_rdy();
    int k;
    k = 0;
    while (rdy_n !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    while (rdy_n !== 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      err_total++;
      end_of_test();
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check(rdy_n, 1'b1);
    rd_chk(8'h10, 32'h0020_0000);
    rd_chk(8'h90, 32'h0000_0010);
    rd_chk(8'h40, 32'h0000_0000);
  endtask

  // Unchopped single conversion with an ADC offset in place
  task automatic t_single();
    host.wr(8'h0C, 32'h0000_0056);
    host.wr(8'h90, 32'h0002_0003);
    host.wr(8'h00, 32'h0000_0001);
    wait_idle(n);
    check(n, 32'h0000_00D6);
    rd_chk(8'h80, 32'h0000_0001);
    rd_chk(8'h04, 32'h0000_0101);
    rd_chk(8'h84, 32'h0012_3400);
    rd_chk(8'h80, 32'h0000_0000);
  endtask

  // Data read in the completing cycle keeps the old result
  task automatic t_drop();
    fa <= 24'h00_0056;
    host.wr(8'h00, 32'h0000_0001);
    repeat (211) @(posedge clk);
    rd_chk(8'h84, 32'h0012_3400);
    rd_chk(8'h84, 32'h0012_3400);
    check(rdy_n, 1'b1);
  endtask

  // Chopped channel with its own filter word averages both halves
  task automatic t_chop();
    host.wr(8'hB0, 32'h0001_0002);
    fa <= 24'h10_0000;
    fb <= 24'h20_0001;
    host.wr(8'h00, 32'h0000_0011);
    wait_idle(n);
    check(n, 32'h0000_0102);
    rd_chk(8'hA4, 32'h0017_FFAA);
  endtask

  // Bipolar range with a negative channel offset
  task automatic t_bipolar();
    host.wr(8'hD0, 32'h0006_0001);
    host.wr(8'hC8, 32'h0040_0010);
    fa <= 24'h20_0000;
    host.wr(8'h00, 32'h0000_0021);
    wait_idle(n);
    rd_chk(8'hC4, 32'h008F_FFE5);
  endtask

  // Continuous mode skips disabled channels one and three and wraps
  task automatic t_cont();
    host.wr(8'h00, 32'h0000_0002);
    wait_rdy();
    repeat (5) @(posedge clk);
    check(mux_ch, 2'h2);
    wait_rdy();
    repeat (5) @(posedge clk);
    check(mux_ch, 2'h0);
    host.wr(8'h00, 32'h0000_0000);
    wait_idle(n);
  endtask

  // Gate held low blocks the start; its rising edge releases it
  task automatic t_gate();
    host.wr(8'h08, 32'h0000_0010);
    pin1_ext <= 1'b0;
    fa       <= 24'h00_0456;
    host.wr(8'h00, 32'h0000_0001);
    repeat (20) @(posedge clk);
    check(busy, 1'b1);
    check(mod_run, 1'b0);
    pin1_ext <= 1'b1;
    ref_low  <= 1'b1;
    wait_idle(n);
    ref_low <= 1'b0;
    check(n >= 214 && n <= 220, 1'b1);
    rd_chk(8'h80, 32'h0000_0003);
    rd_chk(8'h80, 32'h0000_0001);
    rd_chk(8'h84, 32'h0000_0400);
    host.wr(8'h08, 32'h0000_0000);
  endtask

  // Pin zero driven high, pin one left as input
  task automatic t_gpio();
    host.wr(8'h08, 32'h0000_0005);
    repeat (4) @(posedge clk);
    check(io0_drv, 2'b11);
    check(io1_drv.oe, 1'b0);
    rd_chk(8'h08, 32'h0000_0065);
    host.wr(8'h08, 32'h0000_0000);
  endtask

  // Zero-scale self calibration on channel zero
  task automatic t_cal();
    fa <= 24'h00_0123;
    host.wr(8'h0C, 32'h0000_0000);
    host.wr(8'h00, 32'h0000_0003);
    wait_idle(n);
    check(n, 32'h0000_00D6);
    rd_chk(8'h0C, 32'h0000_0123);
    rd_chk(8'h04, 32'h0000_010F);
    check(io1_drv, 2'b01);
  endtask

  // Channel zero-scale, then full-scale system calibration
  task automatic t_syscal();
    fa <= 24'h00_0223;
    host.wr(8'h00, 32'h0000_0004);
    wait_idle(n);
    rd_chk(8'h88, 32'h0000_0100);
    fa <= 24'h40_0223;
    host.wr(8'h00, 32'h0000_0005);
    wait_idle(n);
    rd_chk(8'h8C, 32'h007F_FFFF);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_drop();
    t_chop();
    t_bipolar();
    t_cont();
    t_gate();
    t_gpio();
    t_cal();
    t_syscal();
    end_of_test();
  end
endmodule
